/* core/rkp_pkg.sv */
// Shared constants and carriers of the remote key port pin block
package rkp_pkg;
    localparam int RKP_DW = 32;
    localparam int RKP_AW = 8;
    localparam logic [7:0] RKP_ADDR_SCAN = 8'h00;
    localparam logic [7:0] RKP_ADDR_CTRL = 8'h04;
    localparam logic [7:0] RKP_ADDR_CAR = 8'h08;
    localparam logic [7:0] RKP_ADDR_STAT = 8'h0c;
    localparam int RKP_CTRL_W = 5;
    localparam int RKP_CAR_W = 4;
    localparam int RKP_STAT_RET_LSB = 8;
    localparam int RKP_STAT_S0_BIT = 12;
    localparam int RKP_STAT_S1_BIT = 13;
    localparam int RKP_STAT_POC_BIT = 14;
    localparam int RKP_SYNC_W = 15;
    localparam logic [7:0] RKP_SCAN_RST = 8'hff;
    localparam logic [4:0] RKP_CTRL_RST = 5'h19;
    localparam logic [3:0] RKP_CAR_RST = 4'h0;
    localparam logic [14:0] RKP_SYNC_RST = 15'h4000;
    localparam logic [2:0] RKP_SEL_FX = 3'h0;
    localparam logic [2:0] RKP_SEL_FX8 = 3'h1;
    localparam logic [2:0] RKP_SEL_FX12 = 3'h2;
    localparam logic [2:0] RKP_SEL_HIGH = 3'h3;
    localparam logic [2:0] RKP_SEL_FX2 = 3'h4;
    localparam logic [2:0] RKP_SEL_FX16 = 3'h5;
    localparam logic [2:0] RKP_SEL_FX24 = 3'h6;
    localparam logic [4:0] RKP_HALF_FX = 5'h01;
    localparam logic [4:0] RKP_HALF_FX2 = 5'h02;
    localparam logic [4:0] RKP_HALF_FX8 = 5'h08;
    localparam logic [4:0] RKP_HALF_FX12 = 5'h0c;
    localparam logic [4:0] RKP_HALF_FX16 = 5'h10;
    localparam logic [4:0] RKP_HALF_FX24 = 5'h18;
    localparam int RKP_CLK_MHZ = 20;
    localparam int RKP_POC_TIME_US = 100;
    localparam int RKP_POC_CYCLES = RKP_POC_TIME_US * RKP_CLK_MHZ;

    typedef struct packed {
        logic ret_pd_en;
        logic ind_out_mode;
        logic sense0_in_en;
        logic sense_pd_en;
        logic scan_dir_out;
    } rkp_ctrl_s;

    typedef struct packed {
        logic tx_en;
        logic [2:0] sel;
    } rkp_car_s;
endpackage

/* core/rkp_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module rkp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pins and filtered levels
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [WIDTH-1:0] lvl_next;

    initial begin
        if (WIDTH < 1) $error("rkp_sync width must be at least one");
    end

    always_comb begin
        lvl_next = lvl_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) lvl_next[i] = s3_reg[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            lvl_reg <= RST_VAL;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign level = lvl_reg;
endmodule

/* core/rkp_carrier.sv */
// Carrier generator: divides the system clock into the selected carrier wave
`timescale 1ns/1ps
module rkp_carrier
    import rkp_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Setting and wave
    input wire rkp_car_s car,
    output logic wave
);
    logic [4:0] cnt_reg, cnt_next;
    logic wave_reg, wave_next;
    logic [4:0] half;

    function automatic logic [4:0] half_of(input logic [2:0] sel);
        case (sel)
            RKP_SEL_FX: half_of = RKP_HALF_FX;
            RKP_SEL_FX2: half_of = RKP_HALF_FX2;
            RKP_SEL_FX8: half_of = RKP_HALF_FX8;
            RKP_SEL_FX12: half_of = RKP_HALF_FX12;
            RKP_SEL_FX16: half_of = RKP_HALF_FX16;
            RKP_SEL_FX24: half_of = RKP_HALF_FX24;
            default: half_of = RKP_HALF_FX;
        endcase
    endfunction

    always_comb begin
        half = half_of(car.sel);
        cnt_next = cnt_reg;
        wave_next = wave_reg;
        if (!car.tx_en) begin
            // Parked so that the first enabled cycle starts a high half when sel is unchanged
            cnt_next = half - 5'h01;
            wave_next = 1'b0;
        end else if (car.sel == RKP_SEL_HIGH || car.sel == 3'h7) begin
            cnt_next = '0;
            wave_next = 1'b1;
        end else if (cnt_reg >= half - 5'h01) begin
            cnt_next = '0;
            wave_next = ~wave_reg;
        end else begin
            cnt_next = cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            wave_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            wave_reg <= wave_next;
        end
    end

    assign wave = wave_reg;
endmodule

/* core/rkp_top.sv */
// Remote key port pins: scan, return, sense, indicator, carrier and reset pins behind APB
//
// Behaviour
// - Eight key-scan pins change direction together as one group.
// - Key-scan pins in input direction get pull-downs.
// - Key-scan pins in output direction drive the written scan levels.
// - One setting enables pull-downs of sense input and dual-role pin together.
// - Sense input with input mode removed is off and high impedance.
// - Dual-role pin in input mode is readable as a sense input.
// - Dual-role pin in output mode is the active-low transmit indicator.
// - Indicator goes low in step with the emitted carrier.
// - Carrier output is active high.
// - Carrier selectable: fx, fx/2, fx/8, fx/12, fx/16, fx/24 or constant high.
// - Four key-return pins are inputs; one setting controls their pull-downs.
// - Low level on the reset pin resets the port logic; pin has a pull-up.
// - Power-on clear drives the reset pin low itself.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module rkp_top
    import rkp_pkg::*;
#(
    parameter bit POC_ENABLE = 1'b1,
    parameter int POC_CYCLES = RKP_POC_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [RKP_AW-1:0] paddr,
    input wire logic [RKP_DW-1:0] pwdata,
    output logic [RKP_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Key-scan port
    input wire logic [7:0] key_scan_port_in,
    output logic [7:0] key_scan_port_out,
    output logic [7:0] key_scan_port_oe,
    output logic key_scan_pd_en,
    // Key-return inputs
    input wire logic [3:0] key_return_inputs,
    output logic key_return_pd_en,
    // Sense input zero
    input wire logic sense_input_zero,
    output logic sense0_in_en,
    output logic sense0_pd_en,
    // Dual-role sense and indicator pin
    input wire logic sense_indicator_pin_in,
    output logic sense_indicator_pin_out,
    output logic sense_indicator_pin_oe,
    output logic sense_indicator_pd_en,
    // Carrier output
    output logic carrier_output,
    // Reset pin, open drain with pull-up outside this logic
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe
);
    initial begin
        if (POC_CYCLES < 1 || POC_CYCLES > 65535) $error("rkp_top POC_CYCLES out of range");
    end

    // Pin synchronisers
    logic [RKP_SYNC_W-1:0] sync_pins, sync_lvl;
    assign sync_pins = {reset_pin_in, sense_indicator_pin_in, sense_input_zero,
        key_return_inputs, key_scan_port_in};

    rkp_sync #(.WIDTH(RKP_SYNC_W), .RST_VAL(RKP_SYNC_RST)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(sync_pins),
        .level(sync_lvl)
    );

    logic reset_pin_low;
    assign reset_pin_low = ~sync_lvl[RKP_STAT_POC_BIT];

    // Power-on clear
    logic [15:0] poc_cnt_reg, poc_cnt_next;
    logic poc_active_reg, poc_active_next;

    always_comb begin
        poc_cnt_next = poc_cnt_reg;
        poc_active_next = poc_active_reg;
        if (poc_active_reg) begin
            if (poc_cnt_reg >= 16'(POC_CYCLES - 1)) begin
                poc_active_next = 1'b0;
            end else begin
                poc_cnt_next = poc_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poc_cnt_reg <= '0;
            poc_active_reg <= POC_ENABLE;
        end else begin
            poc_cnt_reg <= poc_cnt_next;
            poc_active_reg <= poc_active_next;
        end
    end

    // Either reset source puts the port back in its reset state
    logic port_rst;
    assign port_rst = poc_active_reg | reset_pin_low;

    // APB slave, one wait state so every answer leaves a flip-flop
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [RKP_DW-1:0] prdata_reg, prdata_next;
    logic wr_take;
    logic [RKP_DW-1:0] stat_word;

    function automatic logic addr_ok(input logic [RKP_AW-1:0] a);
        addr_ok = (a == RKP_ADDR_SCAN) || (a == RKP_ADDR_CTRL) ||
            (a == RKP_ADDR_CAR) || (a == RKP_ADDR_STAT);
    endfunction

    // Registers
    logic [7:0] scan_reg, scan_next;
    rkp_ctrl_s ctrl_reg, ctrl_next;
    rkp_car_s car_reg, car_next;

    always_comb begin
        stat_word = '0;
        stat_word[7:0] = sync_lvl[7:0];
        stat_word[RKP_STAT_RET_LSB +: 4] = sync_lvl[11:8];
        // Off sense input reads low, its buffer is disabled
        stat_word[RKP_STAT_S0_BIT] = sync_lvl[12] & ctrl_reg.sense0_in_en;
        stat_word[RKP_STAT_S1_BIT] = sync_lvl[13] & ~ctrl_reg.ind_out_mode;
        stat_word[RKP_STAT_POC_BIT] = poc_active_reg;
    end

    always_comb begin
        pready_next = psel & penable & ~pready_reg;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        if (psel && penable && !pready_reg) begin
            pslverr_next = ~addr_ok(paddr);
            prdata_next = '0;
            if (!pwrite) begin
                case (paddr)
                    RKP_ADDR_SCAN: prdata_next = {24'h0, scan_reg};
                    RKP_ADDR_CTRL: prdata_next = {27'h0, ctrl_reg};
                    RKP_ADDR_CAR: prdata_next = {28'h0, car_reg};
                    RKP_ADDR_STAT: prdata_next = stat_word;
                    default: prdata_next = '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    assign wr_take = psel & penable & pready_reg & pwrite;

    always_comb begin
        scan_next = scan_reg;
        ctrl_next = ctrl_reg;
        car_next = car_reg;
        if (port_rst) begin
            scan_next = RKP_SCAN_RST;
            ctrl_next = RKP_CTRL_RST;
            car_next = RKP_CAR_RST;
        end else if (wr_take) begin
            case (paddr)
                RKP_ADDR_SCAN: scan_next = pwdata[7:0];
                RKP_ADDR_CTRL: ctrl_next = pwdata[RKP_CTRL_W-1:0];
                RKP_ADDR_CAR: car_next = pwdata[RKP_CAR_W-1:0];
                default: scan_next = scan_reg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_reg <= RKP_SCAN_RST;
            ctrl_reg <= RKP_CTRL_RST;
            car_reg <= RKP_CAR_RST;
        end else begin
            scan_reg <= scan_next;
            ctrl_reg <= ctrl_next;
            car_reg <= car_next;
        end
    end

    // Carrier
    logic wave;
    rkp_carrier u_carrier (
        .pclk(pclk),
        .presetn(presetn),
        .car(car_reg),
        .wave(wave)
    );

    // Pin drivers, all registered except reset_pin_out, which is tied low
    logic [7:0] ks_out_reg, ks_out_next, ks_oe_reg, ks_oe_next;
    logic ks_pd_reg, ks_pd_next, kr_pd_reg, kr_pd_next;
    logic s0_en_reg, s0_en_next, s0_pd_reg, s0_pd_next;
    logic ind_out_reg, ind_out_next, ind_oe_reg, ind_oe_next, ind_pd_reg, ind_pd_next;
    logic car_out_reg, car_out_next, rst_oe_reg, rst_oe_next;

    always_comb begin
        ks_oe_next = {8{ctrl_reg.scan_dir_out}};
        ks_out_next = scan_reg;
        ks_pd_next = ~ctrl_reg.scan_dir_out;
        kr_pd_next = ctrl_reg.ret_pd_en;
        s0_en_next = ctrl_reg.sense0_in_en;
        s0_pd_next = ctrl_reg.sense_pd_en & ctrl_reg.sense0_in_en;
        ind_pd_next = ctrl_reg.sense_pd_en & ~ctrl_reg.ind_out_mode;
        ind_oe_next = ctrl_reg.ind_out_mode;
        // Indicator mirrors the carrier inverted; idles high when not sending
        ind_out_next = ~wave;
        car_out_next = wave;
        rst_oe_next = poc_active_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ks_out_reg <= RKP_SCAN_RST;
            ks_oe_reg <= 8'hff;
            ks_pd_reg <= 1'b0;
            kr_pd_reg <= 1'b1;
            s0_en_reg <= 1'b0;
            s0_pd_reg <= 1'b0;
            ind_out_reg <= 1'b1;
            ind_oe_reg <= 1'b1;
            ind_pd_reg <= 1'b0;
            car_out_reg <= 1'b0;
            rst_oe_reg <= POC_ENABLE;
        end else begin
            ks_out_reg <= ks_out_next;
            ks_oe_reg <= ks_oe_next;
            ks_pd_reg <= ks_pd_next;
            kr_pd_reg <= kr_pd_next;
            s0_en_reg <= s0_en_next;
            s0_pd_reg <= s0_pd_next;
            ind_out_reg <= ind_out_next;
            ind_oe_reg <= ind_oe_next;
            ind_pd_reg <= ind_pd_next;
            car_out_reg <= car_out_next;
            rst_oe_reg <= rst_oe_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign key_scan_port_out = ks_out_reg;
    assign key_scan_port_oe = ks_oe_reg;
    assign key_scan_pd_en = ks_pd_reg;
    assign key_return_pd_en = kr_pd_reg;
    assign sense0_in_en = s0_en_reg;
    assign sense0_pd_en = s0_pd_reg;
    assign sense_indicator_pin_out = ind_out_reg;
    assign sense_indicator_pin_oe = ind_oe_reg;
    assign sense_indicator_pd_en = ind_pd_reg;
    assign carrier_output = car_out_reg;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = rst_oe_reg;

    // Helper logic for the checks below
    logic first_reg;
    logic [4:0] hold_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_reg <= 1'b1;
            hold_reg <= '0;
        end else begin
            first_reg <= 1'b0;
            if (wr_take || port_rst) hold_reg <= '0;
            else if (hold_reg != 5'h1f) hold_reg <= hold_reg + 5'h01;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_scan_group;
        (key_scan_port_oe == 8'hff) || (key_scan_port_oe == 8'h00);
    endproperty
    a_scan_group: assert property (p_scan_group) else $error("scan enables split");

    property p_scan_pd;
        key_scan_pd_en == ~key_scan_port_oe[0];
    endproperty
    a_scan_pd: assert property (p_scan_pd) else $error("scan pull-down wrong");

    sequence s_scan_write;
        wr_take && paddr == RKP_ADDR_SCAN && !port_rst ##1 !port_rst;
    endsequence
    property p_scan_level;
        s_scan_write |=> key_scan_port_out == $past(pwdata[7:0], 2);
    endproperty
    a_scan_level: assert property (p_scan_level) else $error("scan level lost");

    property p_sense_pd;
        ##1 sense0_pd_en |-> $past(ctrl_reg.sense_pd_en);
    endproperty
    a_sense_pd: assert property (p_sense_pd) else $error("sense pull-down stray");

    property p_sense_off;
        !sense0_in_en |-> !sense0_pd_en;
    endproperty
    a_sense_off: assert property (p_sense_off) else $error("off pin not floating");

    property p_ind_carrier;
        carrier_output |-> sense_indicator_pin_out == 1'b0;
    endproperty
    a_ind_carrier: assert property (p_ind_carrier) else $error("indicator not low");

    property p_fx8_high;
        $fell(carrier_output) && car_reg.tx_en && car_reg.sel == RKP_SEL_FX8 &&
            hold_reg > 5'h14 |-> $past(carrier_output, 8) && !$past(carrier_output, 9);
    endproperty
    a_fx8_high: assert property (p_fx8_high) else $error("fx/8 half period wrong");

    property p_idle_low;
        !car_reg.tx_en ##1 !car_reg.tx_en |=> !carrier_output;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("carrier high while idle");

    property p_pin_reset;
        reset_pin_low |=> scan_reg == RKP_SCAN_RST && ctrl_reg == RKP_CTRL_RST;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");

    property p_poc_drive;
        poc_active_reg |=> reset_pin_oe && !reset_pin_out;
    endproperty
    a_poc_drive: assert property (p_poc_drive) else $error("clear not driving pin");

    property p_reset_state;
        first_reg |-> key_scan_port_out == 8'hff && !sense0_in_en &&
            sense_indicator_pin_out && !carrier_output && key_return_pd_en;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");
endmodule

/* test/rkp_keypad_model.sv */
// Key matrix, indicator TRANSMIT_INDICATOR and reset pin model for the port bench
`timescale 1ns/1ps
module rkp_keypad_model (
    // Clock
    input wire logic pclk,
    // Bench controls
    input wire logic [7:0] keys,
    input wire logic s0_lvl,
    input wire logic s1_lvl,
    input wire logic ext_rst_n,
    // Device pin drives
    input wire logic [7:0] scan_out,
    input wire logic [7:0] scan_oe,
    input wire logic scan_pd,
    input wire logic ret_pd,
    input wire logic s1_out,
    input wire logic s1_oe,
    input wire logic s1_pd,
    input wire logic rst_out,
    input wire logic rst_oe,
    // Pin levels seen by the device
    output logic [7:0] scan_in,
    output logic [3:0] ret,
    output logic s0,
    output logic s1,
    output logic rst
);
    logic flip = 1'b0;
    logic [7:0] drv;

    // Undriven lines toggle so a missing pull-down cannot hide behind a settled zero
    always @(posedge pclk) begin
        flip <= ~flip;
    end

    always_comb begin
        // Pull-up on the wire; either the device or the bench may pull it low
        rst = ((rst_oe && !rst_out) || !ext_rst_n) ? 1'b0 : 1'b1;
        drv = scan_oe & scan_out;
        for (int i = 0; i < 8; i++) begin
            scan_in[i] = scan_oe[i] ? scan_out[i] : (scan_pd ? 1'b0 : flip);
        end
        for (int j = 0; j < 4; j++) begin
            ret[j] = (keys[j] & drv[j]) | (keys[j+4] & drv[j+4]);
            if (!ret[j] && !ret_pd) begin
                ret[j] = flip;
            end
        end
        if (!rst) begin
            ret = 4'h0;
        end
        s0 = s0_lvl;
        // In output mode the pin is left open and simply shows the device level
        s1 = s1_oe ? s1_out : (s1_lvl ? 1'b1 : (s1_pd ? 1'b0 : flip));
    end
endmodule

/* test/rkp_top_bench.sv */
// Self-checking bench of the remote key port pin block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module rkp_top_bench
    import rkp_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [RKP_AW-1:0] paddr = '0;
    logic [RKP_DW-1:0] pwdata = '0;
    logic [RKP_DW-1:0] prdata, rd;
    logic pready, pslverr, er;
    logic [7:0] scan_in, scan_out, scan_oe, v;
    logic [7:0] keys = 8'h00;
    logic scan_pd, ret_pd, s0, s0_en, s0_pd, s1_in, s1_out, s1_oe, s1_pd, car_out;
    logic s0_lvl = 1'b0, s1_lvl = 1'b0, ext_rst_n = 1'b1;
    logic rst_in, rst_out, rst_oe;
    logic [3:0] ret;
    logic [4:0] c;
    int err_count = 0, checks = 0, n;
    logic [2:0] sels [6] = '{RKP_SEL_FX, RKP_SEL_FX2, RKP_SEL_FX8, RKP_SEL_FX12,
                             RKP_SEL_FX16, RKP_SEL_FX24};
    int halves [6] = '{1, 2, 8, 12, 16, 24};

    always #25 pclk = ~pclk;

    // Short power-on clear keeps the run brief
    rkp_top #(.POC_ENABLE(1'b1), .POC_CYCLES(20)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .key_scan_port_in(scan_in), .key_scan_port_out(scan_out), .key_scan_port_oe(scan_oe),
        .key_scan_pd_en(scan_pd), .key_return_inputs(ret), .key_return_pd_en(ret_pd),
        .sense_input_zero(s0), .sense0_in_en(s0_en), .sense0_pd_en(s0_pd),
        .sense_indicator_pin_in(s1_in), .sense_indicator_pin_out(s1_out),
        .sense_indicator_pin_oe(s1_oe), .sense_indicator_pd_en(s1_pd),
        .carrier_output(car_out), .reset_pin_in(rst_in), .reset_pin_out(rst_out),
        .reset_pin_oe(rst_oe));

    rkp_keypad_model mdl_u (
        .pclk(pclk), .keys(keys), .s0_lvl(s0_lvl), .s1_lvl(s1_lvl), .ext_rst_n(ext_rst_n),
        .scan_out(scan_out), .scan_oe(scan_oe), .scan_pd(scan_pd), .ret_pd(ret_pd),
        .s1_out(s1_out), .s1_oe(s1_oe), .s1_pd(s1_pd), .rst_out(rst_out), .rst_oe(rst_oe),
        .scan_in(scan_in), .ret(ret), .s0(s0), .s1(s1_in), .rst(rst_in));

    task automatic conclude();
        $display("Totals: checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic hang();
        err_count++;
        conclude();
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until the rising edge that samples pready high
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (t >= 20) begin
            hang();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt(input logic lvl);
        int t;
        t = 0;
        while (car_out !== lvl && t < 80) begin
            @(negedge pclk);
            t++;
        end
        if (t >= 80) begin
            hang();
        end
    endtask

    // Skips the first pulse, which may start mid-count after the setting changes
    task automatic measure(input int h);
        int hi, lo;
        hi = 0;
        lo = 0;
        wt(1'b1);
        wt(1'b0);
        wt(1'b1);
        while (car_out === 1'b1 && hi < 80) begin
            `CHK(s1_out, 1'b0)
            @(negedge pclk);
            hi++;
        end
        while (car_out === 1'b0 && lo < 80) begin
            `CHK(s1_out, 1'b1)
            @(negedge pclk);
            lo++;
        end
        `CHK(hi, h)
        `CHK(lo, h)
    endtask

    function automatic logic [31:0] exp_stat(input logic [4:0] cc, input logic [7:0] vv,
            input logic [7:0] k, input logic a, input logic b);
        logic [7:0] p;
        logic [3:0] r;
        p = cc[0] ? vv : 8'h00;
        r = (p[3:0] & k[3:0]) | (p[7:4] & k[7:4]);
        return {18'h0, ~cc[3] & b, cc[2] & a, r, p};
    endfunction

    initial begin
        void'($urandom(32'ha3f635f8));
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        `CHK(scan_out, 8'hff)
        `CHK(scan_oe, 8'hff)
        `CHK(s0_en, 1'b0)
        `CHK({s1_out, s1_oe}, 2'b11)
        `CHK(car_out, 1'b0)
        `CHK({rst_out, rst_oe}, 2'b01)
        @(posedge pclk);
        presetn <= 1'b1;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (rst_oe === 1'b1 && n < 100);
        `CHK(n >= 20 && n <= 23, 1'b1)
        repeat (8) @(posedge pclk);
        apb(1'b0, RKP_ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h19)
        apb(1'b0, RKP_ADDR_STAT, 32'h0);
        `CHK(rd, exp_stat(5'h19, 8'hff, 8'h00, 1'b0, 1'b0))
        apb(1'b1, RKP_ADDR_STAT, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        $display("Reset and map test done");

        for (int i = 0; i < 12; i++) begin
            c = 5'($urandom) | 5'h12;
            v = 8'($urandom);
            keys <= 8'($urandom);
            s0_lvl <= 1'($urandom);
            s1_lvl <= 1'($urandom);
            if (i < 2) begin
                c[0] = i[0];
            end
            apb(1'b1, RKP_ADDR_SCAN, {24'h0, v});
            apb(1'b1, RKP_ADDR_CTRL, {27'h0, c});
            // Pins follow the register one edge after the write
            repeat (2) @(negedge pclk);
            `CHK(scan_oe, {8{c[0]}})
            `CHK(scan_pd, ~c[0])
            `CHK(scan_out, v)
            `CHK({s0_en, s0_pd, s1_pd}, {c[2], c[2], ~c[3]})
            `CHK(s1_oe, c[3])
            `CHK(ret_pd, c[4])
            repeat (6) @(posedge pclk);
            apb(1'b0, RKP_ADDR_STAT, 32'h0);
            `CHK(rd, exp_stat(c, v, keys, s0_lvl, s1_lvl))
            apb(1'b0, RKP_ADDR_CTRL, 32'h0);
            `CHK(rd, {27'h0, c})
        end
        apb(1'b1, RKP_ADDR_CTRL, 32'h0c);
        repeat (2) @(negedge pclk);
        `CHK({s0_en, s0_pd, s1_pd, ret_pd}, 4'b1000)
        $display("Port direction and input test done");

        apb(1'b1, RKP_ADDR_CTRL, 32'h19);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, RKP_ADDR_CAR, 32'h0);
            repeat (3) @(posedge pclk);
            @(negedge pclk);
            `CHK({car_out, s1_out}, 2'b01)
            apb(1'b1, RKP_ADDR_CAR, {28'h0, 1'b1, sels[k]});
            measure(halves[k]);
        end
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, RKP_ADDR_CAR, {28'h0, 1'b1, k[0] ? 3'h7 : RKP_SEL_HIGH});
            repeat (3) @(posedge pclk);
            repeat (20) begin
                @(negedge pclk);
                `CHK({car_out, s1_out}, 2'b10)
            end
        end
        $display("Carrier test done");

        apb(1'b1, RKP_ADDR_SCAN, 32'h5a);
        repeat (2) @(negedge pclk);
        `CHK(scan_out, 8'h5a)
        @(posedge pclk);
        ext_rst_n <= 1'b0;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        `CHK({scan_out, car_out, s1_out}, {8'hff, 1'b0, 1'b1})
        @(posedge pclk);
        ext_rst_n <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b0, RKP_ADDR_SCAN, 32'h0);
        `CHK(rd, 32'hff)
        $display("Reset pin test done");
        conclude();
    end
endmodule
